// ---- shared/flmo_defs.svh ----
`ifndef FLMO_DEFS_SVH
`define FLMO_DEFS_SVH

// register byte offsets on the apb window
`define FLMO_OFF_CTRL       12'h000
`define FLMO_OFF_IRQ_STAT   12'h004
`define FLMO_OFF_IRQ_MASK   12'h008
`define FLMO_OFF_FAULT_LO   12'h00C
`define FLMO_OFF_FAULT_HI   12'h010
`define FLMO_OFF_FPR_SEL    12'h014
`define FLMO_OFF_FPR_LO     12'h018
`define FLMO_OFF_FPR_HI     12'h01C
`define FLMO_OFF_RETIRED    12'h020

// control register fields
`define FLMO_CTRL_WIDTH_BIT 0
`define FLMO_CTRL_USABLE_BIT 1
`define FLMO_CTRL_MODE64_BIT 2
`define FLMO_CTRL_RESET     3'h0

// interrupt status / mask bit positions
`define FLMO_IRQ_ADDR_BIT   0
`define FLMO_IRQ_UNUSE_BIT  1
`define FLMO_IRQ_TMISS_BIT  2
`define FLMO_IRQ_TINV_BIT   3
`define FLMO_IRQ_BUS_BIT    4
`define FLMO_IRQ_UNIMP_BIT  5
`define FLMO_IRQ_WIDTH      6
`define FLMO_IRQ_RESET      6'h00

// instruction encodings
`define FLMO_OP_LOAD_DOUBLE 6'h35
`define FLMO_OP_LOAD_WORD   6'h31
`define FLMO_OP_COPROC      6'h11
`define FLMO_FN_COPY        6'h06
`define FLMO_SUB_MOVE_FROM  5'h00
`define FLMO_FMT_SINGLE     5'h10
`define FLMO_FMT_DOUBLE     5'h11

`endif

// ---- shared/flmo_pkg.sv ----
package flmo_pkg;

  // instruction handed over by the integer pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] base;
  } flmo_issue_type;

  // load request toward the translation / memory path
  typedef struct packed {
    logic        valid;
    logic        dword;
    logic [63:0] vaddr;
  } flmo_mem_req_type;

  // load answer from the memory path
  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic        bus_err;
    logic        tlb_miss;
    logic        tlb_inv;
  } flmo_mem_rsp_type;

  // integer register write back
  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [63:0] data;
  } flmo_gpr_wr_type;

  // exception causes reported to the pipeline
  typedef enum logic [2:0] {
    FLMO_EXC_NONE,
    FLMO_EXC_ADDR,
    FLMO_EXC_UNUSABLE,
    FLMO_EXC_TLB_MISS,
    FLMO_EXC_TLB_INV,
    FLMO_EXC_BUS,
    FLMO_EXC_UNIMPL
  } flmo_exc_type;

  // control state machine
  typedef enum logic {
    FLMO_IDLE,
    FLMO_LOAD_WAIT
  } flmo_state_type;

endpackage

// ---- hw/flmo_fpu_load_move_ops.sv ----
`timescale 1ns/100ps
`include "flmo_defs.svh"
module flmo_fpu_load_move_ops (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rstn_i,
  // instruction issue from the integer pipeline
  input  wire flmo_pkg::flmo_issue_type   issue_i,
  output logic                           issue_ready_o,
  // memory load path
  output flmo_pkg::flmo_mem_req_type      mem_req_o,
  input  wire flmo_pkg::flmo_mem_rsp_type mem_rsp_i,
  // completion toward the pipeline
  output flmo_pkg::flmo_gpr_wr_type       gpr_wr_o,
  output logic                           done_o,
  output flmo_pkg::flmo_exc_type          exc_o,
  // apb slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // interrupt
  output logic                           irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  flmo_pkg::flmo_state_type state;         // load handshake state
  logic [63:0]              fpr [0:31];    // floating-point register file
  logic [2:0]               ctrl;          // width mode, usable, 64-bit mode
  logic [5:0]               irq_stat;      // sticky event bits
  logic [5:0]               irq_mask;      // event enables
  logic [63:0]              fault_addr;    // address of last faulting load
  logic [4:0]               fpr_sel;       // register picked for apb access
  logic [31:0]              retired;       // count of finished instructions
  logic                     ld_dword;      // pending load is doubleword
  logic [4:0]               ld_ft;         // pending load target
  logic [63:0]              ld_vaddr;      // pending load address

  //////////////////////////////////////////////////////////////////////////////
  // mode bits
  wire fpr_width_mode = ctrl[`FLMO_CTRL_WIDTH_BIT];
  wire cop_usable     = ctrl[`FLMO_CTRL_USABLE_BIT];
  wire mode64         = ctrl[`FLMO_CTRL_MODE64_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // decode of the issued word
  wire        take     = issue_i.valid && issue_ready_o;   // instruction accepted
  wire [5:0]  opcode   = issue_i.instr[31:26];
  wire [4:0]  sub_fmt  = issue_i.instr[25:21];             // format or sub-op
  wire [4:0]  fp_target_reg  = issue_i.instr[20:16];
  wire [4:0]  int_target_reg = issue_i.instr[20:16];
  wire [4:0]  fp_source_reg  = issue_i.instr[15:11];
  wire [4:0]  fp_dest_reg    = issue_i.instr[10:6];
  wire [15:0] offset   = issue_i.instr[15:0];

  wire fp_coproc_opcode   = opcode == `FLMO_OP_COPROC;
  wire load_double_to_fpr = opcode == `FLMO_OP_LOAD_DOUBLE;
  wire load_word_to_fpr   = opcode == `FLMO_OP_LOAD_WORD;
  // move-from needs its zero tail
  // to be a valid encoding
  wire move_word_from_fpr = fp_coproc_opcode && sub_fmt == `FLMO_SUB_MOVE_FROM
                            && issue_i.instr[10:0] == 11'h000;
  // copy: second operand field zero,
  // function code selects copy
  wire fpr_copy = fp_coproc_opcode && issue_i.instr[20:16] == 5'h00
                  && issue_i.instr[5:0] == `FLMO_FN_COPY;
  wire copy_fmt_ok = sub_fmt == `FLMO_FMT_SINGLE
                     || sub_fmt == `FLMO_FMT_DOUBLE;
  wire is_load  = load_double_to_fpr || load_word_to_fpr;
  wire is_known = is_load || move_word_from_fpr || fpr_copy;

  //////////////////////////////////////////////////////////////////////////////
  // address formation
  wire [63:0] sum64 = issue_i.base + {{48{offset[15]}}, offset};
  // 32-bit mode keeps a sign-extended
  // 32-bit address
  wire [63:0] vaddr = mode64 ? sum64 : {{32{sum64[31]}}, sum64[31:0]};
  wire misalign = load_double_to_fpr ? (vaddr[2:0] != 3'h0)
                                     : (vaddr[1:0] != 2'h0);

  //////////////////////////////////////////////////////////////////////////////
  // issue-stage outcome,
  // checked in priority order
  wire exc_unusable = take && is_known && !cop_usable;
  wire exc_misalign = take && is_load && cop_usable && misalign;
  wire exc_unimpl   = take && fpr_copy && cop_usable && !copy_fmt_ok;
  wire start_load   = take && is_load && cop_usable && !misalign;

  //////////////////////////////////////////////////////////////////////////////
  // source read for move-from and copy
  // width clear: odd numbers live
  // in the upper half of the even entry
  wire [4:0]  src_idx  = fpr_width_mode ? fp_source_reg : {fp_source_reg[4:1], 1'b0};
  wire [63:0] src_val  = fpr[src_idx];
  wire [31:0] src_word = (fpr_width_mode || !fp_source_reg[0]) ? src_val[31:0]
                                                               : src_val[63:32];
  // low word to integer side,
  // sign-extended in 64-bit mode
  wire [63:0] mfc_data = mode64 ? {{32{src_word[31]}}, src_word}
                                : {32'h0000_0000, src_word};
  wire do_mfc  = take && move_word_from_fpr && cop_usable;
  // copy is a plain transfer,
  // never routed through arithmetic
  wire do_copy = take && fpr_copy && cop_usable && copy_fmt_ok;
  wire copy_single = sub_fmt == `FLMO_FMT_SINGLE;

  //////////////////////////////////////////////////////////////////////////////
  // copy write: width set copies the whole entry,
  // width clear works on pairs
  // odd numbers in a double copy with width clear are undefined;
  // the lsb is simply dropped
  wire [4:0]  cp_idx = fpr_width_mode ? fp_dest_reg : {fp_dest_reg[4:1], 1'b0};
  wire        cp_half = !fpr_width_mode && copy_single;                         // 32-bit copy
  wire        cp_hi   = cp_half ? fp_dest_reg[0] : 1'b1;
  wire        cp_lo   = cp_half ? !fp_dest_reg[0] : 1'b1;
  wire [63:0] cp_data = cp_half ? {src_word, src_word} : src_val;

  //////////////////////////////////////////////////////////////////////////////
  // load completion
  wire rsp_take = (state == flmo_pkg::FLMO_LOAD_WAIT) && mem_rsp_i.valid;
  wire rsp_err  = mem_rsp_i.bus_err || mem_rsp_i.tlb_miss || mem_rsp_i.tlb_inv;
  wire ld_ok    = rsp_take && !rsp_err;
  // doubleword: even target or width set takes all 64 bits;
  // odd with width clear writes nothing
  wire ldd_we   = ld_dword && (fpr_width_mode || !ld_ft[0]);
  // word: width set clears the undefined upper half,
  // width clear picks a half
  wire [4:0]  ld_idx  = (ld_dword || fpr_width_mode) ? ld_ft : {ld_ft[4:1], 1'b0};
  wire        ld_hi   = ld_dword || fpr_width_mode || ld_ft[0];
  wire        ld_lo   = ld_dword || fpr_width_mode || !ld_ft[0];
  wire [31:0] ld_word = mem_rsp_i.data[31:0];
  wire [63:0] ld_data = ld_dword       ? mem_rsp_i.data
                      : fpr_width_mode ? {32'h0000_0000, ld_word}
                      :                  {ld_word, ld_word};
  wire        ld_we   = ld_ok && (!ld_dword || ldd_we);

  //////////////////////////////////////////////////////////////////////////////
  // apb decode;
  // slave answers in the first access cycle
  wire        apb_setup = psel_i && !penable_i;
  wire        apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
  wire        hit_ctrl  = paddr_i == `FLMO_OFF_CTRL;
  wire        hit_stat  = paddr_i == `FLMO_OFF_IRQ_STAT;
  wire        hit_mask  = paddr_i == `FLMO_OFF_IRQ_MASK;
  wire        hit_flo   = paddr_i == `FLMO_OFF_FAULT_LO;
  wire        hit_fhi   = paddr_i == `FLMO_OFF_FAULT_HI;
  wire        hit_sel   = paddr_i == `FLMO_OFF_FPR_SEL;
  wire        hit_plo   = paddr_i == `FLMO_OFF_FPR_LO;
  wire        hit_phi   = paddr_i == `FLMO_OFF_FPR_HI;
  wire        hit_ret   = paddr_i == `FLMO_OFF_RETIRED;
  wire        hit_any   = hit_ctrl || hit_stat || hit_mask || hit_flo || hit_fhi
                          || hit_sel || hit_plo || hit_phi || hit_ret;
  wire [63:0] sel_val   = fpr[fpr_sel];
  wire [31:0] rd_mux    = hit_ctrl ? {29'h0000_0000, ctrl}
                        : hit_stat ? {26'h000_0000, irq_stat}
                        : hit_mask ? {26'h000_0000, irq_mask}
                        : hit_flo  ? fault_addr[31:0]
                        : hit_fhi  ? fault_addr[63:32]
                        : hit_sel  ? {27'h000_0000, fpr_sel}
                        : hit_plo  ? sel_val[31:0]
                        : hit_phi  ? sel_val[63:32]
                        : hit_ret  ? retired
                        :            32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // single fpr write port;
  // instruction writes take priority over software
  wire        pl_we   = ld_we || do_copy;
  wire        apb_fwe = apb_wr && (hit_plo || hit_phi) && !pl_we;
  wire        fw_en   = pl_we || apb_fwe;
  wire [4:0]  fw_idx  = ld_we ? ld_idx : do_copy ? cp_idx : fpr_sel;
  wire        fw_hi   = ld_we ? ld_hi  : do_copy ? cp_hi  : hit_phi;
  wire        fw_lo   = ld_we ? ld_lo  : do_copy ? cp_lo  : hit_plo;
  wire [63:0] fw_data = ld_we ? ld_data : do_copy ? cp_data : {pwdata_i, pwdata_i};

  //////////////////////////////////////////////////////////////////////////////
  // exception cause for this cycle,
  // reported one edge later
  wire exc_ld_err = rsp_take && rsp_err;
  flmo_pkg::flmo_exc_type next_exc;
  assign next_exc = exc_unusable            ? flmo_pkg::FLMO_EXC_UNUSABLE
                  : exc_misalign            ? flmo_pkg::FLMO_EXC_ADDR
                  : exc_unimpl              ? flmo_pkg::FLMO_EXC_UNIMPL
                  : !exc_ld_err             ? flmo_pkg::FLMO_EXC_NONE
                  : mem_rsp_i.tlb_miss      ? flmo_pkg::FLMO_EXC_TLB_MISS
                  : mem_rsp_i.tlb_inv       ? flmo_pkg::FLMO_EXC_TLB_INV
                  :                           flmo_pkg::FLMO_EXC_BUS;

  // events into the sticky status
  wire [5:0] evt;
  assign evt[`FLMO_IRQ_ADDR_BIT]  = next_exc == flmo_pkg::FLMO_EXC_ADDR;
  assign evt[`FLMO_IRQ_UNUSE_BIT] = next_exc == flmo_pkg::FLMO_EXC_UNUSABLE;
  assign evt[`FLMO_IRQ_TMISS_BIT] = next_exc == flmo_pkg::FLMO_EXC_TLB_MISS;
  assign evt[`FLMO_IRQ_TINV_BIT]  = next_exc == flmo_pkg::FLMO_EXC_TLB_INV;
  assign evt[`FLMO_IRQ_BUS_BIT]   = next_exc == flmo_pkg::FLMO_EXC_BUS;
  assign evt[`FLMO_IRQ_UNIMP_BIT] = next_exc == flmo_pkg::FLMO_EXC_UNIMPL;
  wire [5:0] stat_clr     = (apb_wr && hit_stat) ? pwdata_i[5:0] : 6'h00;
  // a new event in the clearing cycle
  // survives the clear
  wire [5:0] next_stat    = (irq_stat & ~stat_clr) | evt;

  // completion: every accepted instruction
  // except a started load finishes next edge
  wire next_done = (take && !start_load) || rsp_take;

  //////////////////////////////////////////////////////////////////////////////
  // state machine;
  // the only wait is the memory answer
  flmo_pkg::flmo_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      flmo_pkg::FLMO_IDLE: begin
        // only clean loads wait
        if (start_load) begin
          next_state = flmo_pkg::FLMO_LOAD_WAIT;
        end
      end
      flmo_pkg::FLMO_LOAD_WAIT: begin
        // error answers end it too
        if (mem_rsp_i.valid) begin
          next_state = flmo_pkg::FLMO_IDLE;
        end
      end
      default: begin
        // unused encoding
        next_state = flmo_pkg::FLMO_IDLE;
      end
    endcase
  end

  // state, handshake and pending load
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state         <= flmo_pkg::FLMO_IDLE;
      issue_ready_o <= 1'b0;
      ld_dword      <= 1'b0;
      ld_ft         <= 5'h00;
      ld_vaddr      <= 64'h0000_0000_0000_0000;
    end else begin
      state         <= next_state;
      issue_ready_o <= next_state == flmo_pkg::FLMO_IDLE;
      if (start_load) begin
        ld_dword <= load_double_to_fpr;
        ld_ft    <= fp_target_reg;
        ld_vaddr <= vaddr;
      end
    end
  end

  // memory request held
  // until the answer arrives
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mem_req_o <= '0;
    end else if (start_load) begin
      mem_req_o <= '{valid: 1'b1, dword: load_double_to_fpr, vaddr: vaddr};
    end else if (rsp_take) begin
      mem_req_o.valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completion outputs;
  // move-from result lands one edge after issue,
  // so the very next instruction cannot see it yet
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gpr_wr_o <= '0;
      done_o   <= 1'b0;
      exc_o    <= flmo_pkg::FLMO_EXC_NONE;
    end else begin
      gpr_wr_o <= '{valid: do_mfc, idx: int_target_reg, data: mfc_data};
      done_o   <= next_done;
      exc_o    <= next_exc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fpr file with per-half enables;
  // no reset, contents start undefined
  always_ff @(posedge sys_clk_i) begin
    if (fw_en && fw_hi) begin
      fpr[fw_idx][63:32] <= fw_data[63:32];
    end
    if (fw_en && fw_lo) begin
      fpr[fw_idx][31:0] <= fw_data[31:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl     <= `FLMO_CTRL_RESET;
      irq_mask <= `FLMO_IRQ_RESET;
      fpr_sel  <= 5'h00;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        // takes effect at once, mid-load too
        ctrl <= pwdata_i[2:0];
      end
      if (hit_mask) begin
        irq_mask <= pwdata_i[5:0];
      end
      if (hit_sel) begin
        fpr_sel <= pwdata_i[4:0];
      end
    end
  end

  // status, fault address,
  // retire count and interrupt line
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      irq_stat   <= `FLMO_IRQ_RESET;
      fault_addr <= 64'h0000_0000_0000_0000;
      retired    <= 32'h0000_0000;
      irq_o      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      // tracks status on the same edge
      irq_o    <= |(next_stat & irq_mask);
      if (exc_misalign) begin
        fault_addr <= vaddr;
      end else if (exc_ld_err) begin
        fault_addr <= ld_vaddr;
      end
      if (next_done) begin
        // wraps at the top
        retired <= retired + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: registered in setup,
  // valid in the first access cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup && !hit_any;
      prdata_o  <= (apb_setup && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// ---- tb/flmo_mem_model.sv ----
`timescale 1ns/100ps
module flmo_mem_model (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  input  wire flmo_pkg::flmo_mem_req_type mem_req_i,
  input  wire logic [3:0]                 delay_i,
  input  wire logic [2:0]                 err_i,
  output flmo_pkg::flmo_mem_rsp_type      mem_rsp_o
);
  logic [3:0] cnt;  // cycles spent on the open request
  logic       fire; // answer leaves at this edge
  assign fire = mem_req_i.valid & !mem_rsp_o.valid & (cnt == delay_i);
  ////////////////////////////////////////
  // one answer per request; data churns between answers so stale data never looks good
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt       <= 4'h0;
      mem_rsp_o <= '0;
    end else begin
      cnt             <= (fire | !mem_req_i.valid) ? 4'h0 : cnt + 4'h1;
      mem_rsp_o.valid <= fire;
      mem_rsp_o.data  <= fire ? {~mem_req_i.vaddr[31:0], mem_req_i.vaddr[31:0]} : ~mem_rsp_o.data;
      {mem_rsp_o.tlb_miss, mem_rsp_o.tlb_inv, mem_rsp_o.bus_err} <= fire ? err_i : 3'h0;
    end
  end
endmodule

// ---- tb/flmo_chk.sv ----
`timescale 1ns/100ps
`include "flmo_defs.svh"
module flmo_chk (
  input wire logic                       sys_clk_i,
  input wire logic                       rstn_i,
  input wire flmo_pkg::flmo_issue_type   issue_i,
  input wire logic                       issue_ready_o,
  input wire flmo_pkg::flmo_mem_req_type mem_req_o,
  input wire flmo_pkg::flmo_mem_rsp_type mem_rsp_i,
  input wire flmo_pkg::flmo_gpr_wr_type  gpr_wr_o,
  input wire logic                       done_o,
  input wire flmo_pkg::flmo_exc_type     exc_o
);
  // decode of the instruction taken at this edge
  wire        take = issue_i.valid & issue_ready_o;
  wire [5:0]  op   = issue_i.instr[31:26];
  wire        ldd  = take & (op == `FLMO_OP_LOAD_DOUBLE);
  wire        ldw  = take & (op == `FLMO_OP_LOAD_WORD);
  wire        cop  = take & (op == `FLMO_OP_COPROC);
  wire        mfc  = cop & (issue_i.instr[25:21] == `FLMO_SUB_MOVE_FROM);
  wire        cpy  = cop & (issue_i.instr[5:0] == `FLMO_FN_COPY) & (issue_i.instr[20:16] == 5'h00)
                     & (issue_i.instr[25:22] == 4'h8);
  wire [63:0] ea   = issue_i.base + {{48{issue_i.instr[15]}}, issue_i.instr[15:0]};
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_nonload_done: assert property (take & !ldd & !ldw |=> done_o)
    else $error("instruction not finished next cycle");
  a_addr_formed: assert property ($rose(mem_req_o.valid) |-> mem_req_o.vaddr == $past(ea))
    else $error("load address wrong");
  a_dword_kind: assert property ($rose(mem_req_o.valid) |-> mem_req_o.dword == ($past(op) == 6'h35))
    else $error("load size wrong");
  a_dword_align: assert property (ldd & (ea[2:0] != 3'h0) |=> !mem_req_o.valid & done_o
    & (exc_o inside {flmo_pkg::FLMO_EXC_ADDR, flmo_pkg::FLMO_EXC_UNUSABLE})) else $error("dword misalign missed");
  a_word_align: assert property (ldw & (ea[1:0] != 2'h0) |=> !mem_req_o.valid & done_o
    & (exc_o inside {flmo_pkg::FLMO_EXC_ADDR, flmo_pkg::FLMO_EXC_UNUSABLE})) else $error("word misalign missed");
  a_rsp_done: assert property (mem_req_o.valid & mem_rsp_i.valid
    |=> done_o & issue_ready_o & !mem_req_o.valid) else $error("load not closed after answer");
  a_mfc_index: assert property (mfc |=> (gpr_wr_o.valid
    & (gpr_wr_o.idx == $past(issue_i.instr[20:16]))) | (exc_o == flmo_pkg::FLMO_EXC_UNUSABLE))
    else $error("move target wrong");
  a_copy_quiet: assert property (cpy |=> done_o ##0 exc_o inside {flmo_pkg::FLMO_EXC_NONE,
    flmo_pkg::FLMO_EXC_UNUSABLE}) else $error("copy raised exception");
  c_load: cover property (ldd ##1 mem_req_o.valid ##[1:8] mem_rsp_i.valid);
  c_move: cover property (mfc ##1 gpr_wr_o.valid);
  c_addr: cover property (exc_o == flmo_pkg::FLMO_EXC_ADDR);
endmodule

// ---- tb/flmo_tb.sv ----
`timescale 1ns/100ps
`include "flmo_defs.svh"
module testbench;
  logic                       clk  = 1'b0;
  logic                       rstn = 1'b0;
  logic                       psel = 1'b0;
  logic                       pen  = 1'b0;
  logic                       pwr  = 1'b0;
  logic [11:0]                padr = 12'h000;
  logic [31:0]                pwd  = 32'h0000_0000;
  logic [31:0]                prd, rd;
  logic                       prdy, perr, se, irq, rdy, done;
  logic [3:0]                 dly  = 4'h0; // partner answer delay
  logic [2:0]                 err  = 3'h0; // partner fault flags
  logic [63:0]                v;
  flmo_pkg::flmo_issue_type   iss  = '0;
  flmo_pkg::flmo_mem_req_type req;
  flmo_pkg::flmo_mem_rsp_type rsp;
  flmo_pkg::flmo_gpr_wr_type  gwr, g;
  flmo_pkg::flmo_exc_type     exc, e;
  int                         fail_count = 0;
  int                         checked    = 0;
  flmo_fpu_load_move_ops i_flmo_fpu_load_move_ops (.sys_clk_i(clk), .rstn_i(rstn), .issue_i(iss),
    .issue_ready_o(rdy), .mem_req_o(req), .mem_rsp_i(rsp), .gpr_wr_o(gwr), .done_o(done), .exc_o(exc),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .irq_o(irq));
  flmo_mem_model i_flmo_mem_model (.sys_clk_i(clk), .rstn_i(rstn), .mem_req_i(req), .delay_i(dly),
    .err_i(err), .mem_rsp_o(rsp));
  always #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 64'h1, 64'h0);
    if (n >= 16) end_sim();
    rd = prd;
    se = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // offer one instruction, wait for its completion pulse
  task automatic run(input logic [31:0] ins, input logic [63:0] b);
    int n;
    n = 0;
    @(posedge clk);
    iss <= '{1'b1, ins, b};
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    iss.valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    if (n >= 40) chk("done", 64'h1, 64'h0);
    if (n >= 40) end_sim();
    g = gwr;
    e = exc;
  endtask
  task automatic fpr_set(input logic [4:0] r, input logic [63:0] d);
    apb(1'b1, `FLMO_OFF_FPR_SEL, {27'h000_0000, r});
    apb(1'b1, `FLMO_OFF_FPR_LO, d[31:0]);
    apb(1'b1, `FLMO_OFF_FPR_HI, d[63:32]);
  endtask
  task automatic fpr_get(input logic [4:0] r);
    apb(1'b1, `FLMO_OFF_FPR_SEL, {27'h000_0000, r});
    apb(1'b0, `FLMO_OFF_FPR_LO, 32'h0000_0000);
    v[31:0] = rd;
    apb(1'b0, `FLMO_OFF_FPR_HI, 32'h0000_0000);
    v[63:32] = rd;
  endtask
  function automatic logic [31:0] ld(input logic [5:0] o, input logic [4:0] t, input logic [15:0] f);
    return {o, 5'h02, t, f};
  endfunction
  function automatic logic [31:0] mfc(input logic [4:0] t, input logic [4:0] s);
    return {`FLMO_OP_COPROC, `FLMO_SUB_MOVE_FROM, t, s, 11'h000};
  endfunction
  function automatic logic [31:0] cpy(input logic [4:0] f, input logic [4:0] s, input logic [4:0] d);
    return {`FLMO_OP_COPROC, f, 5'h00, s, d, `FLMO_FN_COPY};
  endfunction
  ////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, `FLMO_OFF_CTRL, 32'h0000_0000);
    chk("ctrl", 64'h0, rd);
    apb(1'b0, `FLMO_OFF_IRQ_STAT, 32'h0000_0000);
    chk("status", 64'h0, rd);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("unmapped", 64'h1, se);
    run(mfc(5'h07, 5'h04), 64'h0);
    chk("unusable", flmo_pkg::FLMO_EXC_UNUSABLE, e);
    chk("unusable wr", 64'h0, g.valid);
  endtask
  task automatic t_move();
    apb(1'b1, `FLMO_OFF_CTRL, 32'h0000_0006);
    fpr_set(5'h04, 64'h1111_2222_8000_0001);
    // judged at the write port, never reread in the next slot
    run(mfc(5'h07, 5'h04), 64'h0);
    chk("mv idx", 64'h7, g.idx);
    chk("mv data", 64'hFFFF_FFFF_8000_0001, g.data);
    run(mfc(5'h08, 5'h05), 64'h0);
    chk("mv odd", 64'h1111_2222, g.data);
  endtask
  task automatic t_load();
    apb(1'b1, `FLMO_OFF_CTRL, 32'h0000_0002);
    dly <= 4'h3;
    run(ld(`FLMO_OP_LOAD_DOUBLE, 5'h06, 16'hFFF8), 64'h1000);
    chk("pair exc", flmo_pkg::FLMO_EXC_NONE, e);
    fpr_get(5'h06);
    chk("pair", 64'hFFFF_F007_0000_0FF8, v);
    run(ld(`FLMO_OP_LOAD_WORD, 5'h09, 16'h0004), 64'h2000);
    run(ld(`FLMO_OP_LOAD_WORD, 5'h08, 16'h0008), 64'h2000);
    fpr_get(5'h08);
    chk("word pair", 64'h0000_2004_0000_2008, v);
    run(ld(`FLMO_OP_LOAD_DOUBLE, 5'h07, 16'h0000), 64'h1000);
    chk("odd target", flmo_pkg::FLMO_EXC_NONE, e);
  endtask
  task automatic t_align();
    apb(1'b1, `FLMO_OFF_IRQ_MASK, 32'h0000_0000);
    run(ld(`FLMO_OP_LOAD_DOUBLE, 5'h02, 16'h0004), 64'h1000);
    chk("dw align", flmo_pkg::FLMO_EXC_ADDR, e);
    run(ld(`FLMO_OP_LOAD_WORD, 5'h02, 16'h0002), 64'h1000);
    chk("w align", flmo_pkg::FLMO_EXC_ADDR, e);
    chk("irq masked", 64'h0, irq);
    apb(1'b1, `FLMO_OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b0, `FLMO_OFF_IRQ_STAT, 32'h0000_0000);
    chk("status set", 64'h3, rd);
    chk("irq set", 64'h1, irq);
    apb(1'b1, `FLMO_OFF_IRQ_STAT, 32'h0000_0003);
    apb(1'b0, `FLMO_OFF_IRQ_STAT, 32'h0000_0000);
    chk("status clr", 64'h0, rd);
    chk("irq clr", 64'h0, irq);
  endtask
  // translation miss, translation invalid, bus error in turn
  task automatic t_fault();
    for (int i = 0; i < 3; i++) begin
      err <= 3'h4 >> i;
      run(ld(`FLMO_OP_LOAD_DOUBLE, 5'h02, 16'h0000), 64'h1000);
      chk("fault", 64'(3 + i), e);
    end
    err <= 3'h0;
  endtask
  task automatic t_wide();
    apb(1'b1, `FLMO_OFF_CTRL, 32'h0000_0003);
    dly <= 4'h0;
    run(ld(`FLMO_OP_LOAD_DOUBLE, 5'h03, 16'h0010), 64'h3000);
    fpr_get(5'h03);
    chk("whole", 64'hFFFF_CFEF_0000_3010, v);
    run(ld(`FLMO_OP_LOAD_WORD, 5'h05, 16'h0014), 64'h3000);
    fpr_get(5'h05);
    chk("low word", 64'h3014, v[31:0]);
    run(cpy(`FLMO_FMT_DOUBLE, 5'h03, 5'h0A), 64'h0);
    chk("copy exc", flmo_pkg::FLMO_EXC_NONE, e);
    fpr_get(5'h0A);
    chk("copy d", 64'hFFFF_CFEF_0000_3010, v);
    run(cpy(`FLMO_FMT_SINGLE, 5'h05, 5'h0B), 64'h0);
    fpr_get(5'h0B);
    chk("copy s", 64'h3014, v[31:0]);
    run(cpy(5'h14, 5'h03, 5'h0C), 64'h0);
    chk("bad fmt", flmo_pkg::FLMO_EXC_UNIMPL, e);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_move();
    t_load();
    t_align();
    t_fault();
    t_wide();
    end_sim();
  end
endmodule
bind flmo_fpu_load_move_ops flmo_chk i_flmo_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .issue_i(issue_i),
  .issue_ready_o(issue_ready_o), .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .gpr_wr_o(gpr_wr_o),
  .done_o(done_o), .exc_o(exc_o));
